// file: rtl/timer8_map.vh
// Constants for the 8-bit waveform timer: modes, actions, clock selects, reset values.
// Included by the timer module; definitions only.
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH
`define WGM_NORMAL     2'h0
`define WGM_PHASE      2'h1
`define WGM_CLEAR      2'h2
`define WGM_FAST       2'h3
`define COM_OFF        2'h0
`define COM_TOGGLE     2'h1
`define COM_CLEAR      2'h2
`define COM_SET        2'h3
`define CS_STOP        3'h0
`define CS_DIV1        3'h1
`define CS_DIV8        3'h2
`define CS_DIV32       3'h3
`define CS_DIV64       3'h4
`define CS_DIV128      3'h5
`define CS_DIV256      3'h6
`define CS_DIV1024     3'h7
`define TIMER_MAX      8'hff
`define TIMER_BOTTOM   8'h00
`define RST_COUNT      8'h00
`define RST_COMPARE    8'h00
`define PRESCALE_W     10
`endif

// file: rtl/timer8_waveform.v
// 8-bit timer/counter with one compare channel and output pin control.
// Assumes control inputs are synchronous to I_CLK; I_DDR_OUT likewise.
`timescale 1ns/1ps
`include "timer8_map.vh"
module timer8_waveform (
	input  wire       I_CLK,
	input  wire       I_SYS_RST,
	input  wire [1:0] i_waveform_mode_select,
	input  wire [1:0] i_compare_output_action,
	input  wire [2:0] i_clock_source_select,
	input  wire       i_ddr_out,
	input  wire       i_port_value,
	input  wire       i_force_compare,
	input  wire       i_count_write,
	input  wire [7:0] i_count_wdata,
	input  wire       i_compare_write,
	input  wire [7:0] i_compare_wdata,
	input  wire       i_overflow_clear,
	input  wire       i_match_clear,
	output reg  [7:0] o_timer_count_value,
	output reg  [7:0] o_compare_value_a,
	output reg        o_overflow_flag,
	output reg        o_compare_match_flag_a,
	output reg        o_compare_output_a,
	output reg        o_pin_out,
	output reg        o_pin_oe_n
);
	reg  [`PRESCALE_W-1:0] prescale;
	reg  [7:0]             compare_buf;
	reg                    count_down;
	reg                    block_match;
	reg                    match_pend;
	reg                    tick;
	reg  [7:0]             next_count;
	reg                    next_down;
	reg                    next_oc;
	reg                    next_ovf;
	wire                   pwm_mode;
	wire                   match;
	wire                   at_max;
	wire                   at_bottom;
	wire [`PRESCALE_W-1:0] next_prescale;
	wire                   is_phase;
	wire                   is_fast;
	wire                   act_on;
	wire                   act_pwm;
	wire                   cmp_max;
	wire                   cmp_bottom;
	wire                   top_load;
	wire [7:1]             tap_hit;
	reg                    next_oc_plain;
	reg                    next_oc_fast;
	reg                    next_oc_phase;

	assign pwm_mode      = i_waveform_mode_select[0];
	assign match         = (o_timer_count_value == o_compare_value_a) && !block_match;
	assign at_max        = (o_timer_count_value == `TIMER_MAX);
	assign at_bottom     = (o_timer_count_value == `TIMER_BOTTOM);
	assign next_prescale = prescale + 1'b1;
	assign is_phase      = (i_waveform_mode_select == `WGM_PHASE);
	assign is_fast       = (i_waveform_mode_select == `WGM_FAST);
	assign act_on        = (i_compare_output_action != `COM_OFF);
	assign act_pwm       = i_compare_output_action[1];
	assign cmp_max       = (o_compare_value_a == `TIMER_MAX);
	assign cmp_bottom    = (o_compare_value_a == `TIMER_BOTTOM);
	assign top_load      = pwm_mode && tick && at_max;

	// One tap per prescaled clock select; select 1 is every cycle
	genvar g;
	generate
		for (g = 1; g < 8; g = g + 1) begin : g_tap
			localparam integer TAP_W = (g == 2) ? 3 : (g == 3) ? 5 : (g == 4) ? 6 : (g == 5) ? 7 : (g == 6) ? 8 : 10;
			if (g == 1) begin : g_direct
				assign tap_hit[g] = 1'b1;
			end else begin : g_div
				assign tap_hit[g] = &prescale[TAP_W-1:0];
			end
		end
	endgenerate

	// Tick select from the free prescaler
	always @* begin
		if (i_clock_source_select == `CS_STOP) begin
			tick = 1'b0;
		end else begin
			tick = tap_hit[i_clock_source_select];
		end
	end

	// Counter sequence per mode
	always @* begin
		next_count = o_timer_count_value;
		next_down  = count_down;
		case (i_waveform_mode_select)
			`WGM_NORMAL: begin
				next_count = o_timer_count_value + 8'h01;
			end
			`WGM_CLEAR: begin
				if (match) begin
					next_count = `TIMER_BOTTOM;
				end else begin
					next_count = o_timer_count_value + 8'h01;
				end
			end
			`WGM_FAST: begin
				next_count = o_timer_count_value + 8'h01;
			end
			`WGM_PHASE: begin
				// Full 8-bit range both ways, period 510 ticks
				if (at_max) begin
					next_down  = 1'b1;
					next_count = `TIMER_MAX - 8'h01;
				end else if (at_bottom) begin
					next_down  = 1'b0;
					next_count = 8'h01;
				end else if (count_down) begin
					next_count = o_timer_count_value - 8'h01;
				end else begin
					next_count = o_timer_count_value + 8'h01;
				end
			end
			default: begin
				next_count = o_timer_count_value;
			end
		endcase
	end

	// Overflow event per mode
	always @* begin
		case (i_waveform_mode_select)
			`WGM_PHASE: begin
				next_ovf = at_bottom && count_down;
			end
			`WGM_CLEAR: begin
				next_ovf = at_max;
			end
			`WGM_FAST: begin
				next_ovf = at_max;
			end
			default: begin
				next_ovf = at_max;
			end
		endcase
	end

	// Non-PWM action, used on a match or a forced compare
	always @* begin
		case (i_compare_output_action)
			`COM_TOGGLE: begin
				next_oc_plain = ~o_compare_output_a;
			end
			`COM_CLEAR: begin
				next_oc_plain = 1'b0;
			end
			`COM_SET: begin
				next_oc_plain = 1'b1;
			end
			default: begin
				next_oc_plain = o_compare_output_a;
			end
		endcase
	end

	// Fast PWM; clear/set actions ignore a match at top, so compare at top gives a constant level
	always @* begin
		next_oc_fast = o_compare_output_a;
		if (i_compare_output_action == `COM_TOGGLE) begin
			if (match) begin
				next_oc_fast = ~o_compare_output_a;
			end
		end else if (act_pwm) begin
			if (at_max) begin
				next_oc_fast = ~i_compare_output_action[0];
			end else if (match) begin
				next_oc_fast = i_compare_output_action[0];
			end
		end
	end

	// Phase PWM; extremes pinned at the turning points
	always @* begin
		next_oc_phase = o_compare_output_a;
		if (act_pwm) begin
			if (at_max && cmp_max) begin
				next_oc_phase = ~i_compare_output_action[0];
			end else if (at_bottom && cmp_bottom) begin
				next_oc_phase = i_compare_output_action[0];
			end else if (match && !count_down) begin
				next_oc_phase = i_compare_output_action[0];
			end else if (match && count_down) begin
				next_oc_phase = ~i_compare_output_action[0];
			end
		end
	end

	// Waveform select
	always @* begin
		if (is_phase) begin
			next_oc = next_oc_phase;
		end else if (is_fast) begin
			next_oc = next_oc_fast;
		end else if (match) begin
			next_oc = next_oc_plain;
		end else begin
			next_oc = o_compare_output_a;
		end
	end

	// Free prescaler, held at zero while stopped
	always @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			prescale <= {`PRESCALE_W{1'b0}};
		end else if (i_clock_source_select == `CS_STOP) begin
			prescale <= {`PRESCALE_W{1'b0}};
		end else begin
			prescale <= next_prescale;
		end
	end

	// Software side of the compare register
	always @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			compare_buf <= `RST_COMPARE;
		end else if (i_compare_write) begin
			compare_buf <= i_compare_wdata;
		end
	end

	// Active compare: direct outside PWM, loaded at top in PWM
	always @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			o_compare_value_a <= `RST_COMPARE;
		end else if (!pwm_mode && i_compare_write) begin
			o_compare_value_a <= i_compare_wdata;
		end else if (top_load) begin
			o_compare_value_a <= compare_buf;
		end
	end

	// Software load beats counting and blocks the next match
	always @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			o_timer_count_value <= `RST_COUNT;
			count_down          <= 1'b0;
			block_match         <= 1'b0;
		end else if (i_count_write) begin
			o_timer_count_value <= i_count_wdata;
			block_match         <= 1'b1;
		end else if (tick) begin
			o_timer_count_value <= next_count;
			count_down          <= next_down;
			block_match         <= 1'b0;
		end
	end

	// Match seen on one tick raises the flag on the next
	always @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			match_pend <= 1'b0;
		end else if (tick) begin
			match_pend <= match;
		end
	end

	// Forced compare only outside PWM; no flag, no clear
	always @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			o_compare_output_a <= 1'b0;
		end else if (i_force_compare && !pwm_mode) begin
			o_compare_output_a <= next_oc_plain;
		end else if (tick) begin
			o_compare_output_a <= next_oc;
		end
	end

	// Hardware set wins over software clear
	always @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			o_overflow_flag <= 1'b0;
		end else if (tick && next_ovf) begin
			o_overflow_flag <= 1'b1;
		end else if (i_overflow_clear) begin
			o_overflow_flag <= 1'b0;
		end
	end

	always @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			o_compare_match_flag_a <= 1'b0;
		end else if (tick && match_pend) begin
			o_compare_match_flag_a <= 1'b1;
		end else if (i_match_clear) begin
			o_compare_match_flag_a <= 1'b0;
		end
	end

	// Port value shown while the action is off; enable follows direction bit
	always @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			o_pin_out  <= 1'b0;
			o_pin_oe_n <= 1'b1;
		end else begin
			o_pin_out  <= act_on ? o_compare_output_a : i_port_value;
			o_pin_oe_n <= ~i_ddr_out;
		end
	end

endmodule // timer8_waveform

// file: testbench/timer8_waveform_monitor.sv
// Assertion checker for the 8-bit waveform timer.
// Bound to the timer top module; sees its ports only.
`timescale 1ns/1ps
module timer8_waveform_monitor (
	input wire       I_CLK,
	input wire       I_SYS_RST,
	input wire [1:0] i_waveform_mode_select,
	input wire [1:0] i_compare_output_action,
	input wire [2:0] i_clock_source_select,
	input wire       i_count_write,
	input wire       i_overflow_clear,
	input wire       i_match_clear,
	input wire [7:0] o_timer_count_value,
	input wire [7:0] o_compare_value_a,
	input wire       o_overflow_flag,
	input wire       o_compare_match_flag_a,
	input wire       o_compare_output_a,
	input wire       o_pin_out
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);
	wire       run = i_clock_source_select == 3'h1 && !i_count_write;
	wire [1:0] md  = i_waveform_mode_select;
	wire [7:0] cnt = o_timer_count_value;
	wire       ph  = run && md == 2'h1;
	sequence s_top; ph && cnt == 8'hfe ##1 ph && cnt == 8'hff; endsequence
	sequence s_bottom; ph && cnt == 8'h01 ##1 ph && cnt == 8'h00; endsequence
	a_normal_wrap: assert property (
		run && md == 2'h0 && cnt == 8'hff |=> cnt == 8'h00 && o_overflow_flag) else $error("normal wrap");
	a_normal_step: assert property (
		run && md == 2'h0 && cnt != 8'hff |=> cnt == $past(cnt) + 8'h01) else $error("normal step");
	a_stop_hold: assert property (
		i_clock_source_select == 3'h0 && !i_count_write |=> $stable(cnt)) else $error("stopped count moved");
	a_ovf_sticky: assert property (
		o_overflow_flag && !i_overflow_clear |=> o_overflow_flag) else $error("overflow flag lost");
	a_clear_match: assert property (
		run && md == 2'h2 && cnt == o_compare_value_a && !$past(i_count_write) |=> cnt == 8'h00)
		else $error("no clear on match");
	a_fast_wrap: assert property (
		run && md == 2'h3 && cnt == 8'hff |=> cnt == 8'h00) else $error("fast wrap");
	a_phase_turn: assert property (
		s_top |=> cnt == 8'hfe) else $error("phase turn");
	a_phase_bottom: assert property (
		s_bottom |-> ##[0:1] o_overflow_flag) else $error("phase bottom flag");
	a_match_flag: assert property (
		run && cnt == o_compare_value_a && !$past(i_count_write) && !i_match_clear |-> ##[1:2] o_compare_match_flag_a)
		else $error("match flag");
	a_pin_drive: assert property (
		i_compare_output_action != 2'h0 |=> o_pin_out == $past(o_compare_output_a)) else $error("pin data");
endmodule // timer8_waveform_monitor

// file: testbench/timer8_pin_model.sv
// Port pin outside the timer, with a weak pull-up.
// Fed by the timer's pin data and active-low enable.
`timescale 1ns/1ps
module timer8_pin_model (
	input  wire i_pin_out,
	input  wire i_pin_oe_n,
	output wire o_level
);
	assign o_level = i_pin_oe_n ? 1'b1 : i_pin_out;
endmodule // timer8_pin_model

// file: testbench/tb_timer8_waveform.sv
// Self-checking bench for the 8-bit waveform timer.
// Expects timer8_waveform, its pin model and monitor compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_timer8_waveform;
	logic       I_CLK, I_SYS_RST, ddr, cw, mw, oclr, mclr;
	logic [1:0] mode, act;
	logic [2:0] cs;
	logic [7:0] cdat, mdat;
	wire  [7:0] cnt;
	wire        ovf, mf, pout, poe_n, lvl;
	int         fails, samples_checked, n, i;
	int         tab [7][4] = '{'{3, 2, 8'h40, 65}, '{3, 3, 8'h40, 191}, '{3, 2, 8'hff, 256}, '{1, 2, 8'h40, 128},
		'{1, 3, 8'h40, 382}, '{1, 2, 8'hff, 510}, '{1, 2, 8'h00, 0}};
	timer8_waveform timer8_waveform_inst (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_waveform_mode_select(mode),
		.i_compare_output_action(act), .i_clock_source_select(cs), .i_ddr_out(ddr), .i_port_value(1'b0),
		.i_force_compare(1'b0), .i_count_write(cw), .i_count_wdata(cdat), .i_compare_write(mw),
		.i_compare_wdata(mdat), .i_overflow_clear(oclr), .i_match_clear(mclr), .o_timer_count_value(cnt),
		.o_compare_value_a(), .o_overflow_flag(ovf), .o_compare_match_flag_a(mf), .o_compare_output_a(),
		.o_pin_out(pout), .o_pin_oe_n(poe_n));
	timer8_pin_model timer8_pin_model_inst (.i_pin_out(pout), .i_pin_oe_n(poe_n), .o_level(lvl));
	task automatic tick(input int k);
		repeat (k) @(posedge I_CLK);
		#1;
	endtask
	task automatic cfg(input logic [1:0] m, input logic [1:0] a, input logic [2:0] c);
		@(posedge I_CLK);
		mode <= m; act <= a; cs <= c;
	endtask
	// Count write when c is set, compare write otherwise
	task automatic wr(input logic c, input logic [7:0] d);
		@(posedge I_CLK);
		if (c) begin cw <= 1'b1; cdat <= d; end else begin mw <= 1'b1; mdat <= d; end
		@(posedge I_CLK);
		cw <= 1'b0; mw <= 1'b0;
	endtask
	// One-cycle pulse on both flag clears
	task automatic clr;
		@(posedge I_CLK);
		oclr <= 1'b1; mclr <= 1'b1;
		@(posedge I_CLK);
		oclr <= 1'b0; mclr <= 1'b0;
	endtask
	task automatic gap(output int g);
		logic v;
		g = 0; v = lvl;
		while (lvl === v && g < 600) begin tick(1); g++; end
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin I_CLK = 1'b0; forever #5 I_CLK = ~I_CLK; end
	initial begin #400000; fails++; tally_and_finish(); end
	initial begin
		I_SYS_RST = 1'b1; ddr = 1'b1; cw = 1'b0; mw = 1'b0; mode = 2'h0; act = 2'h0; cs = 3'h0; cdat = 8'h00; mdat = 8'h00;
		oclr = 1'b0; mclr = 1'b0;
		repeat (2) @(posedge I_CLK);
		I_SYS_RST <= 1'b0;
		#1;
		`CHK("count", 8'h00, cnt)
		`CHK("flags", 2'b00, {ovf, mf})
		`CHK("oe_n", 1'b1, poe_n)
		cfg(2'h0, 2'h0, 3'h1);
		wr(1'b1, 8'hfe);
		tick(2);
		`CHK("wrap", 9'h100, {ovf, cnt})
		cfg(2'h0, 2'h0, 3'h0);
		tick(1); n = cnt;
		tick(5);
		`CHK("stop", n[7:0], cnt)
		cfg(2'h2, 2'h1, 3'h1);
		wr(1'b0, 8'h03);
		wr(1'b1, 8'h00);
		clr();
		gap(n); gap(n);
		`CHK("half", 4, n)
		`CHK("mflag", 1'b1, mf)
		`CHK("ctc_ovf", 1'b0, ovf)
		// Duty over one full period; buffered compare settles first
		for (i = 0; i < 7; i++) begin
			cfg(tab[i][0][1:0], tab[i][1][1:0], 3'h1);
			wr(1'b0, tab[i][2][7:0]);
			tick(1100);
			clr();
			n = 0;
			repeat (tab[i][0] == 3 ? 256 : 510) begin tick(1); n += (lvl === 1'b1); end
			`CHK("duty", tab[i][3], n)
			`CHK("pflags", 2'b11, {ovf, mf})
		end
		@(posedge I_CLK);
		ddr <= 1'b0;
		tick(2);
		`CHK("pin", 2'b11, {poe_n, lvl})
		tally_and_finish();
	end
endmodule // tb_timer8_waveform
bind timer8_waveform timer8_waveform_monitor timer8_waveform_monitor_inst (.I_CLK, .I_SYS_RST,
	.i_waveform_mode_select, .i_compare_output_action, .i_clock_source_select, .i_count_write, .i_overflow_clear,
	.i_match_clear, .o_timer_count_value, .o_compare_value_a, .o_overflow_flag, .o_compare_match_flag_a,
	.o_compare_output_a, .o_pin_out);
